/* include/sbx_pkg.sv */
// Purpose: Shared constants for the serial bus port expander.
// Assumes: System clock ref_clk at 100 MHz; bus pins are oversampled.
// Notes:   The fixed address nibble is arbitrary and set per variant.
package sbx_pkg;

    // System clock period in nanoseconds.
    localparam int unsigned SBX_CLK_PERIOD_NS = 10;

    // Number of port lines.
    localparam int unsigned SBX_PORT_WIDTH = 8;

    // Bits per byte on the serial bus.
    localparam int unsigned SBX_BYTE_BITS = 8;

    // Fixed upper address nibble; the value is arbitrary.
    localparam logic [3:0] SBX_FIXED_ADDR = 4'h4;

    // Reset value of the port latch: all lines high.
    localparam logic [7:0] SBX_PORT_RESET = 8'hFF;

    // Position of the direction bit in the address byte.
    localparam int unsigned SBX_RW_BIT = 0;

    // Largest delay from a port change to a valid alert, in nanoseconds.
    localparam int unsigned SBX_ALERT_VALID_NS = 4000;

    // Alert delay in clock cycles; a longest time rounds down.
    localparam int unsigned SBX_ALERT_VALID_CYC = SBX_ALERT_VALID_NS / SBX_CLK_PERIOD_NS;

    // Transfer states of the bus slave.
    typedef enum logic [2:0] {
        SBX_IDLE,
        SBX_ADDR,
        SBX_ADDR_ACK,
        SBX_WR_DATA,
        SBX_WR_ACK,
        SBX_RD_DATA,
        SBX_RD_ACK,
        SBX_IGNORE
    } sbx_state_t;

endpackage : sbx_pkg

/* rtl/sbx_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of asynchronous inputs.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
module sbx_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // First capture stage, read only by the second stage.
    logic [WIDTH-1:0] meta;
    // Next values of both stages.
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync_out;

    // Shift the inputs through the two stages.
    always_comb
    begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    // Register both stages; reset loads the idle level.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            meta     <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end

endmodule // sbx_sync

/* rtl/sbx_expander.sv */
// Purpose: Serial bus slave giving eight quasi-bidirectional port lines.
// Assumes: scl and sda are oversampled by ref_clk; the master keeps bus timing.
// Notes:   Open-drain outputs use enables that are low while the pin is pulled.

// Functional notes
// - Each line is input or output, no direction.
// - Read returns current port levels.
// - Write latches each byte onto port.
// - Three select pins match low address bits.
// - Bus idles high; transfers start from idle.
// - Start is sda falling while scl high.
// - Stop is sda rising while scl high.
// - One bit per scl pulse, stable high.
// - Any bytes per frame, each acknowledged.
// - Slave acknowledges received bytes low.
// - Master nack ends read; slave releases sda.
// - Port input edge asserts low alert.
// - Return to original or access clears alert.
// - Read clears alert at ack after rise.
// - Write clears alert at ack after fall.
// - Change during ack pulse may be lost.
// - Later changes raise alert after next edge.
// - Other devices' accesses leave alert alone.
// - Power-on: lines high, weak pull-up only.
// - Writing high to a low line gives brief strong pull-up.
module sbx_expander
    import sbx_pkg::*;
#(
    parameter logic [3:0] FIXED_ADDR = SBX_FIXED_ADDR
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       scl,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic       addr_select_bit0,
    input  wire logic       addr_select_bit1,
    input  wire logic       addr_select_bit2,
    input  wire logic [7:0] port_in,
    output logic      [7:0] port_out,
    output logic      [7:0] port_oe_n,
    output logic      [7:0] port_strong_pu,
    output logic            alert_out,
    output logic            alert_oe_n
);

    // Synchronised copies of all pins from outside the clock domain.
    logic       scl_s;
    logic       sda_s;
    logic [2:0] sel_s;
    logic [7:0] port_s;

    // Bus pins idle high after reset.
    sbx_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_bus_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({scl, sda_in}),
        .sync_out ({scl_s, sda_s})
    );

    // Select pins and port lines; port lines idle high as the latch does.
    sbx_sync #(.WIDTH(11), .RESET_VAL(11'h7FF)) u_pin_sync (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .async_in ({addr_select_bit2, addr_select_bit1, addr_select_bit0, port_in}),
        .sync_out ({sel_s, port_s})
    );

    // Bus sampling state and transfer control.
    sbx_state_t state;               // Transfer state.
    sbx_state_t next_state;
    logic       scl_d;               // Previous scl sample for edge detection.
    logic       sda_d;               // Previous sda sample for start and stop.
    logic [7:0] shift;               // Receive or transmit shift register.
    logic [7:0] next_shift;
    logic [3:0] bit_cnt;             // Bits of the current byte seen so far.
    logic [3:0] next_bit_cnt;
    logic       sda_low;             // Registered open-drain pull on sda.
    logic       next_sda_low;
    logic [7:0] port_latch;          // Latched output data.
    logic [7:0] next_port_latch;
    logic [7:0] strong_pu;           // Strong pull-up enables.
    logic [7:0] next_strong_pu;
    logic       alert;               // Alert pending, active high inside.
    logic       next_alert;
    logic [7:0] ref_level;           // Port levels at the last clear.
    logic [7:0] next_ref_level;
    logic       alert_clr;           // Clear request from an own-port access.
    logic [2:0] clr_hold;            // Re-arm window that covers the synchroniser delay.
    logic [2:0] next_clr_hold;

    // Edge and condition decode of the synchronised bus lines.
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

    // Address match on the completed address byte.
    function automatic logic addr_hit(input logic [7:0] a, input logic [2:0] sel,
                                      input logic [3:0] fixed);
        addr_hit = (a[7:4] == fixed) && (a[3:1] == sel);
    endfunction

    // Bus slave: shift bits on scl rising, drive sda on scl falling.
    always_comb
    begin
        next_state      = state;
        next_shift      = shift;
        next_bit_cnt    = bit_cnt;
        next_sda_low    = sda_low;
        next_port_latch = port_latch;
        next_strong_pu  = strong_pu;
        alert_clr       = 1'b0;
        if (scl_fall)
        begin
            next_strong_pu = 8'h00;
        end
        if (start_cond)
        begin
            // A start, repeated or not, always restarts address reception.
            next_state   = SBX_ADDR;
            next_bit_cnt = 4'h0;
            next_sda_low = 1'b0;
        end
        else if (stop_cond)
        begin
            next_state   = SBX_IDLE;
            next_sda_low = 1'b0;
        end
        else
        begin
            case (state)
                SBX_IDLE, SBX_IGNORE:
                begin
                    // Foreign traffic touches nothing here.
                    next_sda_low = 1'b0;
                end
                SBX_ADDR, SBX_WR_DATA:
                begin
                    if (scl_rise)
                    begin
                        // One bit per scl pulse, sampled while high.
                        next_shift   = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == 4'(SBX_BYTE_BITS))
                    begin
                        next_bit_cnt = 4'h0;
                        if (state == SBX_ADDR)
                        begin
                            if (addr_hit(shift, sel_s, FIXED_ADDR))
                            begin
                                next_state   = SBX_ADDR_ACK;
                                next_sda_low = 1'b1;
                            end
                            else
                            begin
                                next_state = SBX_IGNORE;
                            end
                        end
                        else
                        begin
                            // Latch each byte and drive it out.
                            next_state      = SBX_WR_ACK;
                            next_sda_low    = 1'b1;
                            next_port_latch = shift;
                            next_strong_pu  = shift & ~port_latch;
                            alert_clr       = 1'b1;
                        end
                    end
                end
                SBX_ADDR_ACK, SBX_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        next_sda_low = 1'b0;
                        if (state == SBX_ADDR_ACK && shift[SBX_RW_BIT])
                        begin
                            // Sample port levels and present the first bit.
                            next_state   = SBX_RD_DATA;
                            next_shift   = {port_s[6:0], 1'b1};
                            next_sda_low = ~port_s[7];
                        end
                        else
                        begin
                            next_state = SBX_WR_DATA;
                        end
                    end
                end
                SBX_RD_DATA:
                begin
                    if (scl_rise)
                    begin
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall)
                    begin
                        if (bit_cnt == 4'(SBX_BYTE_BITS))
                        begin
                            // Release sda for the master's acknowledge.
                            next_state   = SBX_RD_ACK;
                            next_sda_low = 1'b0;
                            next_bit_cnt = 4'h0;
                        end
                        else
                        begin
                            next_sda_low = ~shift[7];
                            next_shift   = {shift[6:0], 1'b1};
                        end
                    end
                end
                SBX_RD_ACK:
                begin
                    if (scl_rise)
                    begin
                        alert_clr = 1'b1;
                        if (sda_s)
                        begin
                            // Nack: stay released until stop.
                            next_state = SBX_IGNORE;
                        end
                    end
                    if (scl_fall)
                    begin
                        // Ack seen: resample port for the next byte.
                        next_state   = SBX_RD_DATA;
                        next_shift   = {port_s[6:0], 1'b1};
                        next_sda_low = ~port_s[7];
                    end
                end
                default:
                begin
                    next_state = SBX_IDLE;
                end
            endcase
        end
    end

    // Change alert: set on a difference from the reference on a released line, cleared on access.
    always_comb
    begin
        next_ref_level = ref_level;
        next_alert     = alert;
        next_clr_hold  = {clr_hold[1:0], alert_clr};
        if (alert_clr || (clr_hold != 3'h0))
        begin
            // Re-arm against the present levels until lines that a write released have
            // crossed the synchroniser, so the write itself raises no alert; a change
            // inside this short window is lost.
            next_ref_level = port_s;
            next_alert     = 1'b0;
        end
        else
        begin
            // Lines driven low are outputs; only released lines act as inputs.
            next_alert = |((port_s ^ ref_level) & port_latch);
        end
    end

    // Register all state; power-on leaves lines high and weakly held.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state      <= SBX_IDLE;
            scl_d      <= 1'b1;
            sda_d      <= 1'b1;
            shift      <= 8'h00;
            bit_cnt    <= 4'h0;
            sda_low    <= 1'b0;
            port_latch <= SBX_PORT_RESET;
            strong_pu  <= 8'h00;
            alert      <= 1'b0;
            ref_level  <= SBX_PORT_RESET;
            clr_hold   <= 3'h0;
        end
        else
        begin
            state      <= next_state;
            scl_d      <= scl_s;
            sda_d      <= sda_s;
            shift      <= next_shift;
            bit_cnt    <= next_bit_cnt;
            sda_low    <= next_sda_low;
            port_latch <= next_port_latch;
            strong_pu  <= next_strong_pu;
            alert      <= next_alert;
            ref_level  <= next_ref_level;
            clr_hold   <= next_clr_hold;
        end
    end

    // Pin drive straight from flip-flops; enables low while pulling low.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            sda_out        <= 1'b0;
            sda_oe_n       <= 1'b1;
            port_out       <= 8'h00;
            port_oe_n      <= 8'hFF;
            port_strong_pu <= 8'h00;
            alert_out      <= 1'b0;
            alert_oe_n     <= 1'b1;
        end
        else
        begin
            sda_out        <= 1'b0;
            sda_oe_n       <= ~next_sda_low;
            port_out       <= 8'h00;
            port_oe_n      <= next_port_latch;
            port_strong_pu <= next_strong_pu;
            alert_out      <= 1'b0;
            alert_oe_n     <= ~next_alert;
        end
    end

endmodule // sbx_expander

/* bench/sbx_expander_assertions.sv */
// Purpose: Concurrent checks on the expander's pins.
// Assumes: The master leaves the bus idle between frames.
// Notes:   Bound into every expander instance.
module sbx_expander_assertions
    import sbx_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       scl,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       addr_select_bit0,
    input wire logic       addr_select_bit1,
    input wire logic       addr_select_bit2,
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_out,
    input wire logic [7:0] port_oe_n,
    input wire logic [7:0] port_strong_pu,
    input wire logic       alert_out,
    input wire logic       alert_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       bus_busy;  // High from a start to a stop on the pins.
    logic       scl_q;     // Pin values one cycle back.
    logic       sda_q;
    logic [7:0] port_q;
    logic [3:0] since_chg; // Cycles since port_in last moved, saturating.
    // Tracks frames and the age of the last port move.
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            bus_busy <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            port_q <= 8'hFF;
            since_chg <= 4'hF;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda_in;
            port_q <= port_in;
            since_chg <= (port_in != port_q) ? 4'h0 : since_chg + {3'h0, since_chg != 4'hF};
            if (scl && scl_q && sda_q && !sda_in)
                bus_busy <= 1'b1;
            else if (scl && scl_q && !sda_q && sda_in)
                bus_busy <= 1'b0;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    // A watched line moves while the bus is idle and no alert is pending.
    sequence s_idle_move;
        !bus_busy && alert_oe_n && $stable(port_oe_n) && ((port_in & port_oe_n) != (port_q & port_oe_n));
    endsequence
    // The port then holds still.
    sequence s_settled;
        $stable(port_in)[*4];
    endsequence
    AST_ALERT_RAISE: assert property (s_idle_move ##1 s_settled |-> ##[0:6] !alert_oe_n)
        else $error("alert not raised after port move");
    AST_ALERT_CAUSE: assert property ($fell(alert_oe_n) |-> since_chg <= 4'hA)
        else $error("alert raised without a port move");
    AST_SPU_RELEASE: assert property (($fell(scl) && (port_strong_pu != 8'h00)) |-> ##[1:6] (port_strong_pu == 8'h00))
        else $error("strong pull-up outlived scl fall");
    AST_SPU_HIGH_ONLY: assert property ((port_strong_pu & ~port_oe_n) == 8'h00)
        else $error("strong pull-up on a line held low");
    AST_SDA_STEADY: assert property ($changed(sda_oe_n) |-> !scl)
        else $error("sda moved while scl high");
    AST_IDLE_NO_PULL: assert property (!bus_busy |-> sda_oe_n)
        else $error("sda pulled on idle bus");
    AST_LATCH_IN_FRAME: assert property ($changed(port_oe_n) |-> bus_busy)
        else $error("port latch moved outside a frame");
    AST_RESET_STATE: assert property ($fell(reset) |-> sda_oe_n && alert_oe_n && (port_oe_n == 8'hFF) && (port_strong_pu == 8'h00))
        else $error("wrong state after reset");
    AST_OPEN_DRAIN: assert property ((sda_out == 1'b0) && (alert_out == 1'b0) && (port_out == 8'h00))
        else $error("open-drain output drives high");
endmodule // sbx_expander_assertions

bind sbx_expander sbx_expander_assertions chk_u (
    .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_select_bit0(addr_select_bit0),
    .addr_select_bit1(addr_select_bit1), .addr_select_bit2(addr_select_bit2),
    .port_in(port_in), .port_out(port_out), .port_oe_n(port_oe_n),
    .port_strong_pu(port_strong_pu), .alert_out(alert_out), .alert_oe_n(alert_oe_n)
);

/* bench/sbx_bus_master.sv */
// Purpose: Behavioural bus master that faces the expander.
// Assumes: Clock pulses are 80 ns: 6 cycles low, 2 high.
// Notes:   sda_rel high lets the pull-up take the line.
module sbx_bus_master
    import sbx_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_rel
);
    timeunit 1ns;
    timeprecision 100ps;
    // Both lines idle high.
    initial
    begin
        scl = 1'b1;
        sda_rel = 1'b1;
    end
    // Waits a number of clock edges.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // One clock pulse; sda moves only while scl is low, sampled at the end of high.
    task automatic bit_cycle(input logic v, output logic s);
        scl <= 1'b0;
        tick(1);
        sda_rel <= v;
        tick(5);
        scl <= 1'b1;
        tick(2);
        s = sda;
    endtask
    // Start: sda falls while scl stays high.
    task automatic bus_start();
        sda_rel <= 1'b0;
        tick(6);
    endtask
    // Stop: sda rises while scl stays high.
    task automatic bus_stop();
        scl <= 1'b0;
        tick(1);
        sda_rel <= 1'b0;
        tick(5);
        scl <= 1'b1;
        tick(6);
        sda_rel <= 1'b1;
        tick(12);
    endtask
    // Sends a byte, most significant bit first, then frees sda for the answer.
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], s);
        bit_cycle(1'b1, s);
        ack = !s;
    endtask
    // Reads a byte and acknowledges it, or not to end the read.
    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, b[i]);
        bit_cycle(!give_ack, s);
    endtask
endmodule // sbx_bus_master

/* bench/serial_bus_port_expander_tb.sv */
// Purpose: Self-checking bench for the port expander.
// Assumes: Port lines have pull-ups; ext_port models outside drivers.
// Notes:   Bus traffic comes from the master model.
module serial_bus_port_expander_tb;
    import sbx_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] SEL = 3'h5;     // Our select pin setting.
    logic       ref_clk = 1'b0;
    logic       reset = 1'b1;
    logic [7:0] ext_port = 8'hFF;          // Outside drive; 1 is released.
    logic [2:0] sel = SEL;
    int         failures = 0;
    int         tests_run = 0;
    logic       scl, sda_rel, sda_out, sda_oe_n, alert_out, alert_oe_n, ack;
    logic [7:0] port_in, port_out, port_oe_n, port_strong_pu, rd;
    wire logic  sda = sda_rel & (sda_oe_n | sda_out); // Pulled-up open-drain wire.
    assign port_in = (port_oe_n & ext_port) | (~port_oe_n & port_out);
    always #(SBX_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    sbx_expander dut_u (
        .ref_clk(ref_clk), .reset(reset), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .addr_select_bit0(sel[0]), .addr_select_bit1(sel[1]),
        .addr_select_bit2(sel[2]), .port_in(port_in), .port_out(port_out),
        .port_oe_n(port_oe_n), .port_strong_pu(port_strong_pu), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n)
    );
    sbx_bus_master m_u (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_rel(sda_rel));
    // Prints the verdict and stops.
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Compares one byte-wide result.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Waits a bounded time for the alert level; a timeout ends the run.
    task automatic wait_alert(input logic lvl);
        for (int n = 0; n < SBX_ALERT_VALID_CYC && alert_oe_n !== lvl; n++)
            @(posedge ref_clk);
        chk({7'h0, alert_oe_n}, {7'h0, lvl});
        if (alert_oe_n !== lvl)
            end_of_test();
    endtask
    // Start plus address byte.
    task automatic frame_addr(input logic [2:0] s, input logic rw);
        m_u.bus_start();
        m_u.send_byte({SBX_FIXED_ADDR, s, rw}, ack);
    endtask
    // Idle state after reset.
    task automatic t_reset();
        chk({sda_oe_n, alert_oe_n, 6'h0}, 8'hC0);
        chk(port_oe_n, 8'hFF);
        chk(port_strong_pu, 8'h00);
    endtask
    // Three bytes in one frame; latch and strong pull-up per byte.
    task automatic t_write();
        frame_addr(SEL, 1'b0);
        chk({7'h0, ack}, 8'h01);
        m_u.send_byte(8'h55, ack);
        chk(port_oe_n, 8'h55);
        chk(port_strong_pu, 8'h00);
        m_u.send_byte(8'hA3, ack);
        chk(port_oe_n, 8'hA3);
        chk(port_strong_pu, 8'hA2);
        m_u.send_byte(8'hFF, ack);
        chk({7'h0, ack}, 8'h01);
        chk(port_strong_pu, 8'h5C);
        m_u.bus_stop();
        chk(port_strong_pu, 8'h00);
        chk(port_oe_n, 8'hFF);
        chk({7'h0, alert_oe_n}, 8'h01);
    endtask
    // Alert raised, kept across a foreign access, cleared by reads.
    task automatic t_alert_read();
        frame_addr(SEL, 1'b1);
        m_u.recv_byte(1'b0, rd);
        m_u.bus_stop();
        chk(rd, 8'hFF);
        wait_alert(1'b1);
        ext_port <= 8'hEF;
        wait_alert(1'b0);
        frame_addr(SEL ^ 3'h1, 1'b0);
        chk({7'h0, ack}, 8'h00);
        m_u.send_byte(8'h00, ack);
        m_u.bus_stop();
        chk(port_oe_n, 8'hFF);
        chk({7'h0, alert_oe_n}, 8'h00);
        frame_addr(SEL, 1'b1);
        m_u.recv_byte(1'b1, rd);
        chk(rd, 8'hEF);
        wait_alert(1'b1);
        ext_port <= 8'h7F;
        m_u.tick(8);
        m_u.recv_byte(1'b0, rd);
        chk(rd, 8'h7F);
        m_u.bus_stop();
        chk({7'h0, sda}, 8'h01);
        wait_alert(1'b1);
    endtask
    // Return to the old value clears; a write clears too.
    task automatic t_return_write();
        ext_port <= 8'hFF;
        wait_alert(1'b0);
        ext_port <= 8'h7F;
        wait_alert(1'b1);
        ext_port <= 8'hFF;
        wait_alert(1'b0);
        frame_addr(SEL, 1'b0);
        m_u.send_byte(8'hFF, ack);
        wait_alert(1'b1);
        m_u.bus_stop();
        chk(port_oe_n, 8'hFF);
    endtask
    // Reset, then the scenarios in turn.
    initial
    begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(posedge ref_clk);
        t_reset();
        t_write();
        t_alert_read();
        t_return_write();
        end_of_test();
    end
endmodule // serial_bus_port_expander_tb
